// [emm_bus_responder.sv]
// External bus model: answers mapper strobes after a set number of cycles.
// Assumes one mapper drives the strobes and address.
`default_nettype none

module emm_bus_responder (
  // Clock
  input wire logic clk_sys_in,
  // Mapper bus
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [23:0] bus_addr_in,
  // Test control
  input wire logic [3:0] wait_in,
  // Answer
  output logic ext_ready_n_out,
  output logic [15:0] ext_rdata_out,
  output logic [23:0] cap_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic active;
  logic [3:0] cnt_reg = 4'h0;
  logic [15:0] last_reg = 16'h0000;
  assign active = !read_strobe_n_in || !write_strobe_n_in;
  // Wait counter; ready only while strobed
  always_ff @(posedge clk_sys_in) begin
    cnt_reg <= active ? cnt_reg + 4'h1 : 4'h0;
  end
  // Capture address and data pattern of each cycle
  always_ff @(posedge clk_sys_in) begin
    if (active) begin
      last_reg <= bus_addr_in[15:0] ^ 16'h5A5A;
      cap_addr_out <= bus_addr_in;
    end
  end
  assign ext_ready_n_out = !(active && cnt_reg >= wait_in);
  // Released bus shows the inverse, so stale data never passes
  assign ext_rdata_out = active ? bus_addr_in[15:0] ^ 16'h5A5A : ~last_reg;
endmodule : emm_bus_responder
`default_nettype wire

// [emm_cfg.svh]
// Constants for the expanded-memory page mapper: I/O offsets, field
// positions, reset values and geometry. Included by the package and modules.
`ifndef EMM_CFG_SVH
`define EMM_CFG_SVH

// I/O offsets of the mapper registers
`define EMM_IDX_ADDR 16'h0026
`define EMM_CTRL_ADDR 16'h0027
`define EMM_FSEL_ADDR 16'h006C
`define EMM_MDL_ADDR 16'h006E
`define EMM_MDH_ADDR 16'h006F

// Index value that opens the control register
`define EMM_IDX_KEY 8'h01
// Reset values
`define EMM_IDX_RST 8'h00
`define EMM_CTRL_RST 8'h00
`define EMM_FSEL_RST 8'h00
`define EMM_MDL_RST 8'h00
`define EMM_MDH_RST 8'h00

// Control register fields
`define EMM_CTRL_WIN_HI 7
`define EMM_CTRL_WIN_LO 6
`define EMM_CTRL_GEN_BIT 4
// Mapping-data high byte fields
`define EMM_MDH_EN_BIT 7
`define EMM_MDH_PAGE_HI 1

// Frame geometry
`define EMM_NUM_FRAMES 12
`define EMM_FRAME_IDX_W 4
`define EMM_PAGE_W 10
`define EMM_OFS_W 14
`define EMM_FIX_HI3 3'b100
`define EMM_WIN_BASE 4'hC
`define EMM_WIN_BAD 2'b11

`endif

// [emm_frame_entry.sv]
// One page frame's mapping-data pair (low and high byte).
// Assumes write enables come from the decoded, frame-selected access.
`default_nettype none
`include "emm_cfg.svh"

module emm_frame_entry
  import emm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Byte writes
  input wire logic we_lo_in,
  input wire logic we_hi_in,
  input wire logic [15:0] wdata_in,
  // Stored mapping
  output emm_entry_s entry_out
);

  logic [7:0] low_reg;
  logic [2:0] high_reg; // Enable plus page bits 23:22

  // Low byte holds page bits 21:14
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      low_reg <= `EMM_MDL_RST;
    end else if (we_lo_in) begin
      low_reg <= wdata_in[7:0];
    end
  end

  // High byte keeps only the enable and two top page bits
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      high_reg <= 3'h0;
    end else if (we_hi_in) begin
      high_reg <= {wdata_in[8+`EMM_MDH_EN_BIT], wdata_in[9:8]};
    end
  end

  // One driver for the whole entry: enable, then page bits 23:14
  assign entry_out = {high_reg, low_reg};

endmodule : emm_frame_entry
`default_nettype wire

// [emm_mapper.sv]
// Expanded-memory page mapper with its I/O register file and bus front.
// Assumes the core presents one request pulse per cycle while not busy;
// external ready is an asynchronous pin and is synchronised here.
//
// Function
// - Mapped addresses swap the top 6 bits for 10 page bits, low 14 bits always pass.
// - Twelve 16 Kbyte frames exist, eight fixed at 80000H to 9FFFFH.
// - Control bits 7:6 place four frames at C, D or E 64K window; 11 maps nothing.
// - Port 0027H is the control register only while the index holds 01H, else external.
// - The index at 0026H resets to 00H and stores all eight bits written.
// - Control bit 4 enables translation; when clear every access is unmapped.
// - A frame whose enable bit is set redirects to its 10-bit page, else untouched.
// - Frame select at 006CH keeps bits 7:2, reads zero in 1:0, and picks the pair.
// - Data low at 006EH holds page bits 21:14; high at 006FH holds enable and top bits.
// - A word write of 8048h at 006EH enables the frame and maps it to 120000H.
// - Register cycles keep all five external strobes high.
// - Register cycles finish with zero waits and ignore external ready.
`default_nettype none
`include "emm_cfg.svh"

module emm_mapper
  import emm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Core cycle request
  input wire logic cyc_valid_in,
  input wire emm_cycle_s cyc_req_in,
  output logic cyc_busy_out,
  output logic cyc_done_out,
  output logic [15:0] cyc_rdata_out,
  // External bus
  output logic [23:0] bus_addr_out,
  output logic [15:0] bus_wdata_out,
  output logic bus_io_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic buffer_enable_n_out,
  output logic buffer_direction_out,
  output logic upper_byte_enable_n_out,
  input wire logic ext_ready_n_in,
  input wire logic [15:0] ext_rdata_in
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  emm_state_e state_reg;
  logic [7:0] index_reg;
  logic [7:0] control_reg;
  logic [5:0] fsel_reg;
  logic [1:0] ready_sync_reg;
  logic [15:0] rdata_s1_reg, rdata_s2_reg;
  logic [1:0] age_reg;
  emm_entry_s entries [`EMM_NUM_FRAMES];

  logic take, wr, internal, ext_end;
  logic lane_lo, lane_hi;
  logic [15:0] a_lo, a_hi;
  logic hit_idx, hit_ctl, hit_fsel, hit_mdl, hit_mdh;
  logic [1:0] win;
  emm_frame_s fsel_frame, mem_frame;
  emm_entry_s sel_entry, mem_entry;
  logic [23:0] addr_next;
  logic [15:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  assign take = cyc_valid_in && (state_reg == EMM_ST_IDLE);
  assign wr = cyc_req_in.write;
  assign win = control_reg[`EMM_CTRL_WIN_HI:`EMM_CTRL_WIN_LO];
  // Even address carries the low lane, upper enable the high lane
  assign lane_lo = !cyc_req_in.addr[0];
  assign lane_hi = !cyc_req_in.ube_n;
  assign a_lo = {cyc_req_in.addr[15:1], 1'b0};
  assign a_hi = {cyc_req_in.addr[15:1], 1'b1};

  assign hit_idx = cyc_req_in.io && lane_lo && (a_lo == `EMM_IDX_ADDR);
  // control visible only behind the key; a word write at 0026H still
  // checks the old index, so the control byte is written only if it already held 01H
  assign hit_ctl = cyc_req_in.io && lane_hi && (a_hi == `EMM_CTRL_ADDR)
                   && (index_reg == `EMM_IDX_KEY);
  assign hit_fsel = cyc_req_in.io && lane_lo && (a_lo == `EMM_FSEL_ADDR);
  assign hit_mdl = cyc_req_in.io && lane_lo && (a_lo == `EMM_MDL_ADDR);
  assign hit_mdh = cyc_req_in.io && lane_hi && (a_hi == `EMM_MDH_ADDR);
  assign internal = hit_idx || hit_ctl || hit_fsel || hit_mdl || hit_mdh;

  // frame select chooses the data pair; unknown values reach none
  assign fsel_frame = emm_frame_lookup(fsel_reg, win);
  // the same lookup places the eight fixed and four window frames
  // the window field moves the four upper frames
  assign mem_frame = emm_frame_lookup(cyc_req_in.addr[19:14], win);

  // Selected entries, zero when no frame matches
  always_comb begin
    sel_entry = '0;
    mem_entry = '0;
    if (fsel_frame.hit) begin
      sel_entry = entries[fsel_frame.idx];
    end
    if (mem_frame.hit) begin
      mem_entry = entries[mem_frame.idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame storage

  // One entry per frame, written through the frame select
  genvar gi;
  generate
    for (gi = 0; gi < `EMM_NUM_FRAMES; gi++) begin : g_frame
      logic hit_me;
      assign hit_me = fsel_frame.hit && (fsel_frame.idx == 4'(gi));
      // a word write fills both bytes of the pair at once
      emm_frame_entry u_entry (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .we_lo_in(take && wr && hit_mdl && hit_me),
        .we_hi_in(take && wr && hit_mdh && hit_me),
        .wdata_in(cyc_req_in.wdata),
        .entry_out(entries[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      index_reg <= `EMM_IDX_RST;
    end else if (take && wr && hit_idx) begin
      index_reg <= cyc_req_in.wdata[7:0];
    end
  end

  // control keeps window and global enable, low bits read zero
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      control_reg <= `EMM_CTRL_RST;
    end else if (take && wr && hit_ctl) begin
      control_reg <= {cyc_req_in.wdata[15:14], 1'b0, cyc_req_in.wdata[12], 4'h0};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      fsel_reg <= 6'(`EMM_FSEL_RST >> 2);
    end else if (take && wr && hit_fsel) begin
      fsel_reg <= cyc_req_in.wdata[7:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Translation and read data

  // low 14 bits always pass through
  // per-frame enable picks the 10-bit page
  always_comb begin
    addr_next = {4'h0, cyc_req_in.addr};
    if (!cyc_req_in.io && control_reg[`EMM_CTRL_GEN_BIT] && mem_frame.hit
        && mem_entry.en) begin
      addr_next = {mem_entry.page, cyc_req_in.addr[`EMM_OFS_W-1:0]};
    end
  end

  // reads return stored contents on their own lanes
  always_comb begin
    rdata_next = 16'h0000;
    if (hit_idx) begin
      rdata_next[7:0] = index_reg;
    end
    if (hit_fsel) begin
      rdata_next[7:0] = {fsel_reg, 2'b00};
    end
    if (hit_mdl) begin
      rdata_next[7:0] = sel_entry.page[7:0];
    end
    if (hit_ctl) begin
      rdata_next[15:8] = control_reg;
    end
    if (hit_mdh) begin
      rdata_next[15:8] = {sel_entry.en, 5'h00, sel_entry.page[9:8]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Ready and read data are pin inputs, two stages before use
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ready_sync_reg <= 2'b11;
      rdata_s1_reg <= 16'h0000;
      rdata_s2_reg <= 16'h0000;
    end else begin
      ready_sync_reg <= {ready_sync_reg[0], ext_ready_n_in};
      rdata_s1_reg <= ext_rdata_in;
      rdata_s2_reg <= rdata_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  // Ready is trusted from the third edge on; before that the sync may hold the last low
  assign ext_end = (state_reg == EMM_ST_EXT) && (age_reg == 2'h2) && !ready_sync_reg[1];
  // External cycles wait on synchronised ready; internal ones never leave idle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_reg <= EMM_ST_IDLE;
      cyc_busy_out <= 1'b0;
      age_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        EMM_ST_IDLE: begin
          age_reg <= 2'h0;
          if (take && !internal) begin
            state_reg <= EMM_ST_EXT;
            cyc_busy_out <= 1'b1;
          end
        end
        EMM_ST_EXT: begin
          if (age_reg != 2'h2) begin
            age_reg <= age_reg + 2'h1;
          end
          if (ext_end) begin
            state_reg <= EMM_ST_IDLE;
            cyc_busy_out <= 1'b0;
          end
        end
      endcase
    end
  end

  // Completion pulse and read data
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cyc_done_out <= 1'b0;
      cyc_rdata_out <= 16'h0000;
    end else begin
      cyc_done_out <= 1'b0;
      // register cycles done next edge, ready not consulted
      if (take && internal) begin
        cyc_done_out <= 1'b1;
        cyc_rdata_out <= rdata_next;
      end else if (ext_end) begin
        cyc_done_out <= 1'b1;
        cyc_rdata_out <= rdata_s2_reg;
      end
    end
  end

  // Address and data latched at the start of an external cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bus_addr_out <= 24'h00_0000;
      bus_wdata_out <= 16'h0000;
      bus_io_out <= 1'b0;
    end else if (take && !internal) begin
      bus_addr_out <= addr_next;
      bus_wdata_out <= cyc_req_in.wdata;
      bus_io_out <= cyc_req_in.io;
    end
  end

  // strobes only go low for external cycles, so register cycles
  // leave every one of them high
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || ext_end) begin
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      buffer_enable_n_out <= 1'b1;
      buffer_direction_out <= 1'b1;
      upper_byte_enable_n_out <= 1'b1;
    end else if (take && !internal) begin
      read_strobe_n_out <= wr;
      write_strobe_n_out <= !wr;
      buffer_enable_n_out <= 1'b0;
      buffer_direction_out <= wr; // Low steers the buffer toward the core
      upper_byte_enable_n_out <= cyc_req_in.ube_n;
    end
  end

endmodule : emm_mapper
`default_nettype wire

// [emm_mapper_properties.sv]
// Port assertions for the page mapper.
// Assumes it is bound to emm_mapper and sees only its ports.
`default_nettype none

module emm_mapper_properties
  import emm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Core side
  input wire logic cyc_valid_in,
  input wire emm_cycle_s cyc_req_in,
  input wire logic cyc_busy_out,
  input wire logic cyc_done_out,
  input wire logic [15:0] cyc_rdata_out,
  // External bus
  input wire logic [23:0] bus_addr_out,
  input wire logic bus_io_out,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic buffer_enable_n_out,
  input wire logic buffer_direction_out,
  input wire logic upper_byte_enable_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////
  // Take and register decode; 0027 left out as it hangs on the index
  logic take;
  logic reg_hit;
  logic idle;
  assign take = cyc_valid_in && !cyc_busy_out;
  assign reg_hit = cyc_req_in.io && (cyc_req_in.addr == 20'h0_0026 ||
    cyc_req_in.addr == 20'h0_006C || cyc_req_in.addr == 20'h0_006E ||
    (cyc_req_in.addr == 20'h0_006F && !cyc_req_in.ube_n));
  assign idle = read_strobe_n_out && write_strobe_n_out && buffer_enable_n_out &&
    buffer_direction_out && upper_byte_enable_n_out;
  ////////////////////////////////////////////////////////////////
  // zero waits
  a_reg_zero_wait: assert property (take && reg_hit |=> cyc_done_out && !cyc_busy_out)
    else $error("register cycle took waits");
  a_reg_strobes_high: assert property (take && reg_hit |-> idle ##1 idle)
    else $error("strobe active in register cycle");
  a_idle_strobes: assert property (!cyc_busy_out |-> idle)
    else $error("strobe active while idle");
  a_low_bits_pass: assert property ($rose(cyc_busy_out) |->
    bus_addr_out[13:0] == $past(cyc_req_in.addr[13:0]))
    else $error("low address bits changed");
  a_io_unmapped: assert property ($rose(cyc_busy_out) && bus_io_out |->
    bus_addr_out == {4'h0, $past(cyc_req_in.addr)})
    else $error("io address translated");
  a_outside_frames: assert property ($rose(cyc_busy_out) && !bus_io_out &&
    $past(cyc_req_in.addr[19:17]) != 3'b100 && !($past(cyc_req_in.addr[19:18]) == 2'b11 &&
    $past(cyc_req_in.addr[17:16]) != 2'b11) |-> bus_addr_out == {4'h0, $past(cyc_req_in.addr)})
    else $error("address outside frames translated");
  a_addr_hold: assert property (cyc_busy_out && $past(cyc_busy_out) |-> $stable(bus_addr_out))
    else $error("bus address moved in cycle");
  a_rdata_hold: assert property (!cyc_done_out |-> $stable(cyc_rdata_out))
    else $error("read data moved without done");
  // Main scenarios
  c_reg_cycle: cover property (take && reg_hit);
  c_ext_mapped: cover property ($rose(cyc_busy_out) && bus_addr_out[23:20] != 4'h0);
  c_io_ext: cover property ($rose(cyc_busy_out) && bus_io_out);
endmodule : emm_mapper_properties

bind emm_mapper emm_mapper_properties i_emm_mapper_properties (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cyc_valid_in(cyc_valid_in),
  .cyc_req_in(cyc_req_in), .cyc_busy_out(cyc_busy_out), .cyc_done_out(cyc_done_out),
  .cyc_rdata_out(cyc_rdata_out), .bus_addr_out(bus_addr_out), .bus_io_out(bus_io_out),
  .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
  .buffer_enable_n_out(buffer_enable_n_out), .buffer_direction_out(buffer_direction_out),
  .upper_byte_enable_n_out(upper_byte_enable_n_out));
`default_nettype wire

// [emm_pkg.sv]
// Types shared by the page mapper modules.
// Assumes emm_cfg.svh is reachable on the include path.
`default_nettype none
`include "emm_cfg.svh"

package emm_pkg;

  // One core bus cycle request
  typedef struct packed {
    logic io;
    logic write;
    logic ube_n;
    logic [19:0] addr;
    logic [15:0] wdata;
  } emm_cycle_s;

  // One frame's stored mapping
  typedef struct packed {
    logic en;
    logic [`EMM_PAGE_W-1:0] page;
  } emm_entry_s;

  // Frame lookup result
  typedef struct packed {
    logic hit;
    logic [`EMM_FRAME_IDX_W-1:0] idx;
  } emm_frame_s;

  typedef enum logic [0:0] {
    EMM_ST_IDLE = 1'b0,
    EMM_ST_EXT = 1'b1
  } emm_state_e;

  // Upper six address bits to frame index; window 11 matches nothing
  function automatic emm_frame_s emm_frame_lookup(input logic [5:0] hi6,
                                                  input logic [1:0] win);
    emm_frame_s r;
    r = '0;
    if (hi6[5:3] == `EMM_FIX_HI3) begin
      r.hit = 1'b1;
      r.idx = {1'b0, hi6[2:0]};
    end else if (win != `EMM_WIN_BAD && hi6[5:2] == (`EMM_WIN_BASE + {2'b00, win})) begin
      r.hit = 1'b1;
      r.idx = {2'b10, hi6[1:0]};
    end
    return r;
  endfunction : emm_frame_lookup

endpackage : emm_pkg
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the page mapper with a bus responder model.
// Assumes package, mapper, responder and checker are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import emm_pkg::*;
  // Stimulus and observation
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc_valid_in = 1'b0;
  emm_cycle_s cyc_req_in = '0;
  logic [3:0] wait_v = 4'h0;
  logic busy, done, io, rd_n, wr_n, ben_n, bdir, ube_n, rdy_n;
  logic [15:0] rdata, wdata, xdata, rd_v;
  logic [23:0] addr, cap_addr;
  int errors = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int n_v = 0;
  emm_mapper i_emm_mapper (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .cyc_valid_in(cyc_valid_in), .cyc_req_in(cyc_req_in), .cyc_busy_out(busy),
    .cyc_done_out(done), .cyc_rdata_out(rdata), .bus_addr_out(addr), .bus_wdata_out(wdata),
    .bus_io_out(io), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
    .buffer_enable_n_out(ben_n), .buffer_direction_out(bdir),
    .upper_byte_enable_n_out(ube_n), .ext_ready_n_in(rdy_n), .ext_rdata_in(xdata));
  emm_bus_responder i_emm_bus_responder (.clk_sys_in(clk_sys_in), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .bus_addr_in(addr), .wait_in(wait_v),
    .ext_ready_n_out(rdy_n), .ext_rdata_out(xdata), .cap_addr_out(cap_addr));
  always #20 clk_sys_in = ~clk_sys_in;
  // Hang guard, far above the roughly 125 cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic results;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One core cycle: held through its take edge, then bounded wait for done
  task automatic cyc(input emm_cycle_s c);
    @(negedge clk_sys_in);
    cyc_valid_in = 1'b1;
    cyc_req_in = c;
    @(negedge clk_sys_in);
    cyc_valid_in = 1'b0;
    n_v = 1;
    while (done !== 1'b1 && n_v < 40) begin
      @(negedge clk_sys_in);
      n_v++;
    end
    rd_v = rdata;
    chk("cycle done", 24'(done), 24'h00_0001);
  endtask : cyc
  task automatic rg(input logic w, input logic [19:0] a, input logic [15:0] d, input logic u);
    cyc('{1'b1, w, u, a, d});
    chk("reg wait", 24'(n_v), 24'h00_0001);
  endtask : rg
  task automatic mem(input logic [19:0] a, input logic [23:0] exp);
    cyc('{1'b0, 1'b0, 1'b0, a, 16'h0000});
    chk("bus addr", cap_addr, exp);
    chk("mem data", 24'(rd_v), 24'(exp[15:0] ^ 16'h5A5A));
  endtask : mem
  ////////////////////////////////////////////////////////////////
  // state after reset
  task automatic t_reset;
    rg(1'b0, 20'h0_0026, 16'h0000, 1'b1);
    chk("index rst", 24'(rd_v[7:0]), 24'h00_0000);
    cyc('{1'b1, 1'b0, 1'b0, 20'h0_0027, 16'h0000});
    chk("ctrl gated", cap_addr, 24'h00_0027);
    mem(20'h8_0010, 24'h08_0010);
    cyc('{1'b0, 1'b1, 1'b0, 20'h8_0020, 16'hBEEF});
    chk("bus wdata", 24'(wdata), 24'h00_BEEF);
    chk("write addr", cap_addr, 24'h08_0020);
  endtask : t_reset
  task automatic t_index;
    rg(1'b1, 20'h0_0026, 16'h00FF, 1'b1);
    rg(1'b0, 20'h0_0026, 16'h0000, 1'b1);
    chk("index bits", 24'(rd_v[7:0]), 24'h00_00FF);
    rg(1'b1, 20'h0_0026, 16'h0001, 1'b1);
    rg(1'b1, 20'h0_0027, 16'h1000, 1'b0);
    rg(1'b0, 20'h0_0027, 16'h0000, 1'b0);
    chk("ctrl back", 24'(rd_v[15:8]), 24'h00_0010);
  endtask : t_index
  task automatic t_map;
    rg(1'b1, 20'h0_006C, 16'h00C0, 1'b1);
    rg(1'b1, 20'h0_006E, 16'h8048, 1'b0);
    rg(1'b0, 20'h0_006E, 16'h0000, 1'b0);
    chk("data pair", 24'(rd_v), 24'h00_8048);
    mem(20'hC_1234, 24'h12_1234);
    rg(1'b1, 20'h0_006C, 16'h0084, 1'b1);
    rg(1'b1, 20'h0_006E, 16'h8203, 1'b0);
    rg(1'b0, 20'h0_006C, 16'h0000, 1'b1);
    chk("fsel back", 24'(rd_v[7:0]), 24'h00_0084);
    mem(20'h8_4ABC, 24'h80_CABC);
    mem(20'h8_8000, 24'h08_8000);
  endtask : t_map
  task automatic t_window;
    logic [3:0] hi;
    for (int w = 0; w < 3; w++) begin
      hi = 4'(4'hC + w);
      rg(1'b1, 20'h0_0027, {2'(w), 6'h10, 8'h00}, 1'b0);
      rg(1'b1, 20'h0_006C, {8'h00, hi, 4'h4}, 1'b1);
      rg(1'b1, 20'h0_006E, {8'h80, 8'(8'h50 + w)}, 1'b0);
      mem({hi, 16'h4010}, {10'(10'h050 + w), 14'h0010});
    end
    rg(1'b1, 20'h0_0027, 16'hD000, 1'b0);
    mem(20'hF_4010, 24'h0F_4010);
    rg(1'b1, 20'h0_0027, 16'h8000, 1'b0);
    mem(20'hE_4010, 24'h0E_4010);
  endtask : t_window
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_index();
    t_map();
    wait_v = 4'h3;
    t_window();
    results();
  end
endmodule : tb_top
`default_nettype wire
